// *** verilog/switch_stat_counter_readout.sv ***
// Indirect register window for reading per-port statistics counters
`default_nettype none
`include "stat_regs.svh"
module switch_stat_counter_readout #(
    parameter int NUM_PORTS = `NUM_PORTS
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire stat_pkg::bus_req_t bus_i,
    input wire stat_pkg::evt_t evt_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o
);
    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] table_sel;
    logic [7:0] index_trig;
    logic [7:0] ctrl;
    stat_pkg::result_t result;
    logic [7:0] next_table_sel;
    logic [7:0] next_index_trig;
    logic [7:0] next_ctrl;
    stat_pkg::result_t next_result;
    logic [7:0] next_rdata;
    logic next_rvalid;

    logic trig;
    logic tbl_ok;
    logic tbl_drop;
    logic [NUM_PORTS-1:0] flush_mask;
    logic [NUM_PORTS-1:0] freeze_mask;
    logic [35:0] rd_value;
    logic rd_ovf;
    logic rd_hit;

    function automatic logic wr_to(input stat_pkg::bus_req_t b,
                                   input logic [7:0] a);
        wr_to = b.wr && (b.addr == a);
    endfunction

    // ****************************************
    // Decode
    // ****************************************
    assign trig = wr_to(bus_i, `REG_INDEX_TRIG);
    assign tbl_drop = (table_sel == `TABLE_DROP);
    assign tbl_ok = (table_sel == `TABLE_STAT) || tbl_drop;
    // Flush acts on the write itself; the bit is never stored
    assign flush_mask = (wr_to(bus_i, `REG_GLOBAL_CTRL)
        && bus_i.wdata[`CTRL_FLUSH_BIT])
        ? bus_i.wdata[NUM_PORTS-1:0] : '0;
    assign freeze_mask = ctrl[`CTRL_FREEZE_BIT]
        ? ctrl[NUM_PORTS-1:0] : '0;

    stat_counter_bank #(
        .NUM_PORTS(NUM_PORTS),
        .STAT_PER_PORT(`PORT_BASE),
        .DROP_PER_PORT(`DROP_PER_PORT)
    ) bank (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .evt_i(evt_i),
        .clr_en_i(trig && tbl_ok),
        .clr_drop_i(tbl_drop),
        .clr_index_i({1'b0, bus_i.wdata}),
        .flush_mask_i(flush_mask),
        .freeze_mask_i(freeze_mask),
        .rd_value_o(rd_value),
        .rd_ovf_o(rd_ovf),
        .rd_hit_o(rd_hit)
    );

    // ****************************************
    // Next values
    // ****************************************
    always_comb begin
        next_table_sel = table_sel;
        next_index_trig = index_trig;
        next_ctrl = ctrl;
        next_result = result;
        if (wr_to(bus_i, `REG_TABLE_SEL))
            next_table_sel = bus_i.wdata;
        if (wr_to(bus_i, `REG_GLOBAL_CTRL))
            next_ctrl = bus_i.wdata & 8'h3f;
        if (trig) begin
            next_index_trig = bus_i.wdata;
            next_result = '0;
            // Unknown table or index returns an invalid, zero result
            if (tbl_ok && rd_hit) begin
                next_result.ovf = rd_ovf;
                next_result.valid = 1'b1;
                next_result.value = {1'b0, rd_value};
            end
        end
    end

    always_comb begin
        // One-edge answer with no wait state keeps a full readout short
        next_rvalid = bus_i.rd;
        case (bus_i.addr)
            `REG_TABLE_SEL: next_rdata = table_sel;
            `REG_INDEX_TRIG: next_rdata = index_trig;
            `REG_GLOBAL_CTRL: next_rdata = ctrl;
            `REG_DATA4: next_rdata = result[39:32];
            `REG_DATA3: next_rdata = result[31:24];
            `REG_DATA2: next_rdata = result[23:16];
            `REG_DATA1: next_rdata = result[15:8];
            `REG_DATA0: next_rdata = result[7:0];
            default: next_rdata = 8'h00;
        endcase
        if (!bus_i.rd)
            next_rdata = rdata_o;
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            table_sel <= 8'h00;
            index_trig <= 8'h00;
            ctrl <= `CTRL_RESET;
            result <= '0;
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
        end else begin
            table_sel <= next_table_sel;
            index_trig <= next_index_trig;
            ctrl <= next_ctrl;
            result <= next_result;
            rdata_o <= next_rdata;
            rvalid_o <= next_rvalid;
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    ovf_flag_a: assert property (
        trig && tbl_ok && rd_hit |=> result.ovf == $past(rd_ovf))
        else $error("overflow flag does not follow counter");
    valid_flag_a: assert property (
        trig |=> result.valid == $past(tbl_ok && rd_hit))
        else $error("valid flag wrong after trigger");
    total_reserved_a: assert property (
        result.value[36] == 1'b0 && result.zero == 1'b0)
        else $error("reserved result bits set");
    drop_reserved_a: assert property (
        trig && tbl_drop && bus_i.wdata[1]
        |=> result.value[36:16] == 21'h0)
        else $error("drop counter exceeds 16 bits");
    stat_reserved_a: assert property (
        trig && table_sel == `TABLE_STAT |=> result.value[36:30] == 7'h0)
        else $error("statistics counter exceeds 30 bits");
    read_clear_a: assert property (
        (trig && tbl_ok && rd_hit && !evt_i.valid
            && !(|flush_mask)) ##1
        (!bus_i.wr && !evt_i.valid) ##1
        (trig && $stable(table_sel) && bus_i.wdata == index_trig
            && !evt_i.valid)
        |=> result.value == 37'h0)
        else $error("counter not cleared by readout");
    freeze_ctrl_a: assert property (
        wr_to(bus_i, `REG_GLOBAL_CTRL) |=>
        freeze_mask == ($past(bus_i.wdata[`CTRL_FREEZE_BIT])
            ? $past(bus_i.wdata[NUM_PORTS-1:0]) : '0))
        else $error("freeze mask does not follow control write");
    byte_order_a: assert property (
        bus_i.rd && bus_i.addr == `REG_DATA4 && !trig
        |=> rvalid_o && rdata_o == result[39:32])
        else $error("high result byte not at first data register");
    low_byte_a: assert property (
        bus_i.rd && bus_i.addr == `REG_DATA0 && !trig
        |=> rvalid_o && rdata_o == result[7:0])
        else $error("low result byte not at last data register");

    // ****************************************
    // Register access checks
    // ****************************************
    read_strobe_a: assert property (
        bus_i.rd |=> rvalid_o)
        else $error("read not answered on the next edge");
    read_idle_a: assert property (
        !bus_i.rd |=> !rvalid_o)
        else $error("answer strobe without a read");
    rdata_hold_a: assert property (
        !bus_i.rd |=> $stable(rdata_o))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (
        bus_i.rd && bus_i.addr < `REG_TABLE_SEL
            && bus_i.addr != `REG_GLOBAL_CTRL
        |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    table_store_a: assert property (
        wr_to(bus_i, `REG_TABLE_SEL) |=> table_sel == $past(bus_i.wdata))
        else $error("table select not stored");
    index_store_a: assert property (
        trig |=> index_trig == $past(bus_i.wdata))
        else $error("trigger index not stored");
    invalid_zero_a: assert property (
        trig && !(tbl_ok && rd_hit) |=> result == '0)
        else $error("refused read left a non-zero result");
    total_value_a: assert property (
        trig && tbl_drop && !bus_i.wdata[1] && rd_hit
        |=> result.value[35:0] == $past(rd_value))
        else $error("byte counter value not captured");
    drop_value_a: assert property (
        trig && tbl_drop && bus_i.wdata[1] && rd_hit
        |=> result.value[15:0] == $past(rd_value[15:0]))
        else $error("drop counter value not captured");
    byte3_place_a: assert property (
        bus_i.rd && bus_i.addr == `REG_DATA3 && !trig
        |=> rvalid_o && rdata_o == result[31:24])
        else $error("result bits 31 to 24 misplaced");
    byte2_place_a: assert property (
        bus_i.rd && bus_i.addr == `REG_DATA2 && !trig
        |=> rvalid_o && rdata_o == result[23:16])
        else $error("result bits 23 to 16 misplaced");
    byte1_place_a: assert property (
        bus_i.rd && bus_i.addr == `REG_DATA1 && !trig
        |=> rvalid_o && rdata_o == result[15:8])
        else $error("result bits 15 to 8 misplaced");
    ctrl_bits_a: assert property (
        wr_to(bus_i, `REG_GLOBAL_CTRL) |=> ctrl[7:6] == 2'b00)
        else $error("flush bit stored in control register");

    stat_read_c: cover property (
        trig && table_sel == `TABLE_STAT ##1 result.valid);
    drop_read_c: cover property (
        trig && tbl_drop ##1 result.valid);
    overflow_c: cover property (trig ##1 result.ovf);
    flush_c: cover property (|flush_mask);
    back_to_back_c: cover property (trig ##2 trig);
endmodule
`default_nettype wire

// *** verilog/stat_regs.svh ***
// Register offsets, field positions and constants of the counter readout
`ifndef STAT_REGS_SVH
`define STAT_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_GLOBAL_CTRL 8'h08
`define REG_TABLE_SEL 8'h6e
`define REG_INDEX_TRIG 8'h6f
`define REG_DATA4 8'h74
`define REG_DATA3 8'h75
`define REG_DATA2 8'h76
`define REG_DATA1 8'h77
`define REG_DATA0 8'h78

// ****************************************
// Codes and fields
// ****************************************
`define TABLE_STAT 8'h1c
`define TABLE_DROP 8'h1d
`define RES_OVF_BIT 38
`define RES_VALID_BIT 37
`define STAT_WIDTH 30
`define TOTAL_WIDTH 36
`define DROP_WIDTH 16
`define PORT_BASE 32
`define DROP_PER_PORT 4
`define NUM_PORTS 5
`define CTRL_FREEZE_BIT 5
`define CTRL_FLUSH_BIT 7
`define CTRL_RESET 8'h00

// ****************************************
// Timing figures
// ****************************************
`define POLL_PERIOD_S 30
`define READOUT_ACCESSES 163
`define SPI_CLKS_PER_ACCESS 8

`endif

// *** verilog/stat_pkg.sv ***
// Types shared by the counter readout modules
`default_nettype none
package stat_pkg;
    typedef struct packed {
        logic valid;
        logic drop_tbl;
        logic [8:0] index;
        logic [15:0] amount;
    } evt_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic zero;
        logic ovf;
        logic valid;
        logic [36:0] value;
    } result_t;
endpackage
`default_nettype wire

// *** verilog/stat_counter_bank.sv ***
// Counter storage with read-clear, flush and freeze
`default_nettype none
`include "stat_regs.svh"
module stat_counter_bank #(
    parameter int NUM_PORTS = 5,
    parameter int STAT_PER_PORT = 32,
    parameter int DROP_PER_PORT = 4
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire stat_pkg::evt_t evt_i,
    input wire logic clr_en_i,
    input wire logic clr_drop_i,
    input wire logic [8:0] clr_index_i,
    input wire logic [NUM_PORTS-1:0] flush_mask_i,
    input wire logic [NUM_PORTS-1:0] freeze_mask_i,
    output logic [35:0] rd_value_o,
    output logic rd_ovf_o,
    output logic rd_hit_o
);
    localparam int STAT_SLOTS = NUM_PORTS * STAT_PER_PORT;
    localparam int SLOTS = STAT_SLOTS + NUM_PORTS * DROP_PER_PORT;

    logic [35:0] cnt [SLOTS];
    logic ovf [SLOTS];
    logic [35:0] next_cnt [SLOTS];
    logic next_ovf [SLOTS];

    function automatic logic in_range(input logic drop, input logic [8:0] idx);
        if (drop)
            in_range = int'(idx) < NUM_PORTS * DROP_PER_PORT;
        else
            in_range = int'(idx) < STAT_SLOTS;
    endfunction

    function automatic int slot_of(input logic drop, input logic [8:0] idx);
        slot_of = drop ? STAT_SLOTS + int'(idx) : int'(idx);
    endfunction

    function automatic int port_of(input int s);
        if (s < STAT_SLOTS)
            port_of = s / `PORT_BASE;
        else
            port_of = (s - STAT_SLOTS) / DROP_PER_PORT;
    endfunction

    // Drop table order per port: rx bytes, tx bytes, rx drops, tx drops
    function automatic logic [35:0] mask_of(input int s);
        if (s < STAT_SLOTS)
            mask_of = {{(36-`STAT_WIDTH){1'b0}}, {`STAT_WIDTH{1'b1}}};
        else if (((s - STAT_SLOTS) % DROP_PER_PORT) < 2)
            mask_of = {36{1'b1}};
        else
            mask_of = {{(36-`DROP_WIDTH){1'b0}}, {`DROP_WIDTH{1'b1}}};
    endfunction

    always_comb begin
        int cs;
        int es;
        logic [36:0] sum;
        logic [35:0] m;
        cs = 0;
        es = 0;
        sum = '0;
        m = '0;
        for (int s = 0; s < SLOTS; s++) begin
            next_cnt[s] = cnt[s];
            next_ovf[s] = ovf[s];
            if (flush_mask_i[port_of(s)]) begin
                next_cnt[s] = '0;
                next_ovf[s] = 1'b0;
            end
        end
        if (clr_en_i && in_range(clr_drop_i, clr_index_i)) begin
            cs = slot_of(clr_drop_i, clr_index_i);
            next_cnt[cs] = '0;
            next_ovf[cs] = 1'b0;
        end
        // Event lands after the clear, so a same-cycle hit survives
        if (evt_i.valid && in_range(evt_i.drop_tbl, evt_i.index)) begin
            es = slot_of(evt_i.drop_tbl, evt_i.index);
            if (!freeze_mask_i[port_of(es)]) begin
                m = mask_of(es);
                sum = {1'b0, next_cnt[es]} + {21'h0, evt_i.amount};
                next_cnt[es] = sum[35:0] & m;
                if ((sum & ~{1'b0, m}) != 37'h0)
                    next_ovf[es] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int s = 0; s < SLOTS; s++) begin
                cnt[s] <= '0;
                ovf[s] <= 1'b0;
            end
        end else begin
            for (int s = 0; s < SLOTS; s++) begin
                cnt[s] <= next_cnt[s];
                ovf[s] <= next_ovf[s];
            end
        end
    end

    always_comb begin
        rd_hit_o = in_range(clr_drop_i, clr_index_i);
        rd_value_o = '0;
        rd_ovf_o = 1'b0;
        if (rd_hit_o) begin
            rd_value_o = cnt[slot_of(clr_drop_i, clr_index_i)];
            rd_ovf_o = ovf[slot_of(clr_drop_i, clr_index_i)];
        end
    end
endmodule
`default_nettype wire

// *** test/stat_host_model.sv ***
// Host model driving the counter readout register window
`default_nettype none
`include "stat_regs.svh"
module stat_host_model (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    input wire logic rvalid_i,
    output var stat_pkg::bus_req_t bus_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial bus_o = '0;

    // Entered just after a rising edge; an idle edge follows each access
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bus_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
        bus_o <= '0;
        @(posedge clk_i);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        bus_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk_i);
        bus_o <= '0;
        #1;
        // Missing answer strobe turns into unknown data
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
        @(posedge clk_i);
    endtask

    // Select, trigger, then fetch; drop reads may skip DATA3 and DATA2
    task automatic read_counter(input logic [7:0] tbl, input logic [7:0] idx,
                                input logic full, output logic [39:0] res);
        logic [7:0] b;
        res = '0;
        wr(`REG_TABLE_SEL, tbl);
        wr(`REG_INDEX_TRIG, idx);
        for (int i = 0; i < 5; i++) begin
            if (full || i == 0 || i > 2) begin
                rd(8'(`REG_DATA4 + i), b);
                res[39-8*i -: 8] = b;
            end
        end
    endtask
endmodule
`default_nettype wire

// *** test/tb.sv ***
// Self-checking testbench of the counter readout
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_i = 1'b0;
    logic rstn_i;
    stat_pkg::evt_t evt_i;
    stat_pkg::bus_req_t bus;
    logic [7:0] rdata;
    logic rvalid;
    int failures = 0;
    int checks_done = 0;

    always #10 clk_i = ~clk_i;

    switch_stat_counter_readout u_dut (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .bus_i(bus),
        .evt_i(evt_i),
        .rdata_o(rdata),
        .rvalid_o(rvalid)
    );

    stat_host_model u_host (
        .clk_i(clk_i),
        .rdata_i(rdata),
        .rvalid_i(rvalid),
        .bus_o(bus)
    );

    // ****************************************
    // Helpers
    // ****************************************
    task automatic stop_test();
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ev(input logic d, input logic [8:0] i,
                      input logic [15:0] n);
        evt_i <= '{valid: 1'b1, drop_tbl: d, index: i, amount: n};
        @(posedge clk_i);
        evt_i <= '0;
        @(posedge clk_i);
    endtask

    function automatic logic [39:0] res(input logic o, input logic v,
                                        input logic [35:0] n);
        return {1'b0, o, v, 1'b0, n};
    endfunction

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic s_stat_table();
        logic [39:0] r;
        logic [7:0] b;
        u_host.rd(8'h08, b);
        chk({32'h0, b}, 40'h0);
        ev(1'b0, 9'h00d, 16'h0005);
        ev(1'b0, 9'h00d, 16'h0003);
        ev(1'b0, 9'h02d, 16'h0007);
        ev(1'b0, 9'h08d, 16'h0001);
        u_host.read_counter(8'h1c, 8'h0d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h8));
        u_host.read_counter(8'h1c, 8'h0d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h0));
        u_host.read_counter(8'h1c, 8'h2d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h7));
        u_host.read_counter(8'h1c, 8'h8d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h1));
        // Second trigger two edges later must see the slot already cleared
        ev(1'b0, 9'h04d, 16'h0002);
        u_host.wr(8'h6e, 8'h1c);
        u_host.wr(8'h6f, 8'h4d);
        u_host.wr(8'h6f, 8'h4d);
        for (int i = 0; i < 5; i++) begin
            u_host.rd(8'(8'h74 + i), b);
            r[39-8*i -: 8] = b;
        end
        chk(r, res(1'b0, 1'b1, 36'h0));
    endtask

    task automatic s_drop_table();
        logic [39:0] r;
        ev(1'b1, 9'h003, 16'h1234);
        u_host.read_counter(8'h1d, 8'h03, 1'b0, r);
        chk(r, res(1'b0, 1'b1, 36'h1234));
        ev(1'b1, 9'h000, 16'hffff);
        ev(1'b1, 9'h000, 16'hffff);
        u_host.read_counter(8'h1d, 8'h00, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h1_fffe));
        ev(1'b1, 9'h013, 16'h0009);
        u_host.read_counter(8'h1d, 8'h13, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h9));
        // Drop counters are 16 bits wide, so this wraps to one
        ev(1'b1, 9'h002, 16'hffff);
        ev(1'b1, 9'h002, 16'h0002);
        u_host.read_counter(8'h1d, 8'h02, 1'b0, r);
        chk(r, res(1'b1, 1'b1, 36'h1));
        u_host.read_counter(8'h1d, 8'h02, 1'b0, r);
        chk(r, res(1'b0, 1'b1, 36'h0));
    endtask

    task automatic s_control();
        logic [39:0] r;
        logic [7:0] b;
        ev(1'b0, 9'h00d, 16'h0004);
        u_host.wr(8'h08, 8'h81);
        u_host.read_counter(8'h1c, 8'h0d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h0));
        u_host.wr(8'h08, 8'h21);
        u_host.rd(8'h08, b);
        chk({32'h0, b}, 40'h21);
        ev(1'b0, 9'h00d, 16'h0009);
        ev(1'b0, 9'h02d, 16'h0002);
        u_host.read_counter(8'h1c, 8'h0d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h0));
        u_host.read_counter(8'h1c, 8'h2d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h2));
        u_host.wr(8'h08, 8'h00);
        ev(1'b0, 9'h00d, 16'h0003);
        u_host.read_counter(8'h1c, 8'h0d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h3));
    endtask

    task automatic s_capture_edge();
        logic [39:0] r;
        logic [7:0] b;
        ev(1'b0, 9'h02d, 16'h0006);
        u_host.wr(8'h6e, 8'h1c);
        // Event lands on the very edge that captures and clears the slot
        evt_i <= '{valid: 1'b1, drop_tbl: 1'b0, index: 9'h02d, amount: 16'h3};
        fork
            u_host.wr(8'h6f, 8'h2d);
            begin
                @(posedge clk_i);
                evt_i <= '0;
            end
        join
        for (int i = 0; i < 5; i++) begin
            u_host.rd(8'(8'h74 + i), b);
            r[39-8*i -: 8] = b;
        end
        chk(r, res(1'b0, 1'b1, 36'h6));
        u_host.read_counter(8'h1c, 8'h2d, 1'b1, r);
        chk(r, res(1'b0, 1'b1, 36'h3));
        u_host.read_counter(8'h1e, 8'h0d, 1'b1, r);
        chk(r, 40'h0);
        u_host.read_counter(8'h1d, 8'h14, 1'b1, r);
        chk(r, 40'h0);
        u_host.rd(8'h6e, b);
        chk({32'h0, b}, 40'h1d);
        u_host.rd(8'h6f, b);
        chk({32'h0, b}, 40'h14);
        u_host.rd(8'h50, b);
        chk({32'h0, b}, 40'h0);
    endtask

    initial begin
        rstn_i = 1'b0;
        evt_i = '0;
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        s_stat_table();
        s_drop_table();
        s_control();
        s_capture_edge();
        stop_test();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        #100000;
        failures++;
        stop_test();
    end
endmodule
`default_nettype wire
